// *** verilog/bsse_consts.vh ***
`ifndef BSSE_CONSTS_VH
`define BSSE_CONSTS_VH

// ====================================================================
// register byte offsets
`define BSSE_ADDR_CMD       12'h000
`define BSSE_ADDR_OPERAND   12'h004
`define BSSE_ADDR_OFFSET    12'h008
`define BSSE_ADDR_PC        12'h00C
`define BSSE_ADDR_FLAGS     12'h010
`define BSSE_ADDR_RESULT    12'h014
`define BSSE_ADDR_STATUS    12'h018

// ====================================================================
// field positions
`define BSSE_CMD_OP_MSB     4
`define BSSE_CMD_OP_LSB     0
`define BSSE_CMD_BIT_MSB    7
`define BSSE_CMD_BIT_LSB    5
`define BSSE_CMD_TWO_WORD   8
`define BSSE_OPD_RD_MSB     7
`define BSSE_OPD_RD_LSB     0
`define BSSE_OPD_RR_MSB     15
`define BSSE_OPD_RR_LSB     8
`define BSSE_OPD_IO_MSB     23
`define BSSE_OPD_IO_LSB     16
`define BSSE_OFS_MSB        6
`define BSSE_STS_BUSY       0
`define BSSE_STS_CYC_LSB    1
`define BSSE_STS_CYC_MSB    2
`define BSSE_STS_TAKEN      3

// ====================================================================
// status register bit positions
`define BSSE_FLAG_C         0
`define BSSE_FLAG_Z         1
`define BSSE_FLAG_N         2
`define BSSE_FLAG_V         3
`define BSSE_FLAG_S         4
`define BSSE_FLAG_H         5
`define BSSE_FLAG_T         6
`define BSSE_FLAG_I         7

// ====================================================================
// reset values
`define BSSE_RST_PC         16'h0000
`define BSSE_RST_FLAGS      8'h00
`define BSSE_RST_CMD        9'h000
`define BSSE_RST_OPERAND    24'h000000
`define BSSE_RST_OFFSET     7'h00

// ====================================================================
// timing counts in cycles
`define BSSE_CYC_ONE        2'h1
`define BSSE_CYC_TWO        2'h2
`define BSSE_CYC_THREE      2'h3

// ====================================================================
// operation codes
`define BSSE_OP_CMPC        5'h00
`define BSSE_OP_CMPI        5'h01
`define BSSE_OP_SKRC        5'h02
`define BSSE_OP_SKRS        5'h03
`define BSSE_OP_SKIC        5'h04
`define BSSE_OP_SKIS        5'h05
`define BSSE_OP_BFS         5'h06
`define BSSE_OP_BFC         5'h07
`define BSSE_OP_BEQ         5'h08
`define BSSE_OP_BNE         5'h09
`define BSSE_OP_BCS         5'h0A
`define BSSE_OP_BCC         5'h0B
`define BSSE_OP_BSH         5'h0C
`define BSSE_OP_BLO         5'h0D
`define BSSE_OP_BMI         5'h0E
`define BSSE_OP_BPL         5'h0F
`define BSSE_OP_BGE         5'h10
`define BSSE_OP_BLT         5'h11
`define BSSE_OP_BHS         5'h12
`define BSSE_OP_BHC         5'h13
`define BSSE_OP_BTS         5'h14
`define BSSE_OP_BTC         5'h15
`define BSSE_OP_BVS         5'h16
`define BSSE_OP_BVC         5'h17
`define BSSE_OP_BIE         5'h18
`define BSSE_OP_BID         5'h19
`define BSSE_OP_SHLL        5'h1A
`define BSSE_OP_SHRL        5'h1B
`define BSSE_OP_ROTL        5'h1C
`define BSSE_OP_ROTR        5'h1D
`define BSSE_OP_SHRA        5'h1E

`endif

// *** verilog/bsse_exec.v ***
// Function
// RULE_01 - compares subtract without writeback, set Z C N V S H, one cycle
// RULE_02 - register bit clear skip: skip next when bit 0, flags untouched
// RULE_03 - register bit set skip: skip next when bit 1, flags untouched
// RULE_04 - io bit clear skip: skip next when io bit 0, flags untouched
// RULE_05 - io bit set skip: skip next when io bit 1
// RULE_06 - generic flag set branch jumps to pc+k+1, 1 or 2 cycles
// RULE_07 - generic flag clear branch jumps when indexed flag is 0
// RULE_08 - equal branch on Z set, not equal branch on Z clear
// RULE_09 - carry set and lower on C=1; carry clear and same-higher on C=0
// RULE_10 - minus branch on N=1, plus branch on N=0
// RULE_11 - signed ge on N xor V = 0, signed lt on N xor V = 1
// RULE_12 - half carry branches on H set or clear
// RULE_13 - transfer bit branches on T set or clear
// RULE_14 - overflow branches on V set or clear, flags intact
// RULE_15 - interrupt branches on I set or clear
// RULE_16 - logical left shift clears bit 0, updates Z C N V H
// RULE_17 - logical right shift clears bit 7, updates Z C N V only
// RULE_18 - rotate left takes old carry into bit 0, bit 7 into carry
// RULE_19 - rotate right takes old carry into bit 7, bit 0 into carry
// RULE_20 - arithmetic right shift keeps bit 7, updates Z C N V
// RULE_21 - skip adds 2 over one word, 3 over two words, cycles match
// RULE_22 - signed word offset added to pc+1; untaken branch advances one
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "bsse_consts.vh"

module bsse_exec
(
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // core state
    output reg [15:0] pc_out,
    output reg [7:0] status_register_out,
    output reg busy
);

// ====================================================================
// state and storage
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_EXEC = 3'b010;
localparam [2:0] ST_WAIT = 3'b100;

reg [2:0] state_q;
reg [2:0] state_d;
reg [8:0] cmd_q;
reg [23:0] operand_q;
reg [6:0] offset_q;
reg [15:0] pc_q;
reg [7:0] status_register_q;
reg [7:0] result_q;
reg [1:0] cyc_q;
reg taken_q;
reg [1:0] cnt_q;
reg [1:0] cnt_d;

wire setup_ph;
wire apb_fire;
wire [4:0] op;
wire [2:0] bidx;
wire [7:0] rd_v;
wire [7:0] rr_v;
wire [7:0] io_v;
wire [15:0] ofs_ext;

assign setup_ph = psel & ~penable;
assign apb_fire = psel & penable & pready;
assign op = cmd_q[`BSSE_CMD_OP_MSB:`BSSE_CMD_OP_LSB];
assign bidx = cmd_q[`BSSE_CMD_BIT_MSB:`BSSE_CMD_BIT_LSB];
assign rd_v = operand_q[`BSSE_OPD_RD_MSB:`BSSE_OPD_RD_LSB];
assign rr_v = operand_q[`BSSE_OPD_RR_MSB:`BSSE_OPD_RR_LSB];
assign io_v = operand_q[`BSSE_OPD_IO_MSB:`BSSE_OPD_IO_LSB];
assign ofs_ext = {{9{offset_q[`BSSE_OFS_MSB]}}, offset_q}; // RULE_22

// ====================================================================
// address decode
function mapped;
    input [11:0] a;
    begin
        case (a)
            `BSSE_ADDR_CMD, `BSSE_ADDR_OPERAND, `BSSE_ADDR_OFFSET,
            `BSSE_ADDR_PC, `BSSE_ADDR_FLAGS, `BSSE_ADDR_RESULT,
            `BSSE_ADDR_STATUS:
                mapped = 1'b1;
            default:
                mapped = 1'b0;
        endcase
    end
endfunction

function [31:0] read_mux;
    input [11:0] a;
    input [8:0] cmd;
    input [23:0] opd;
    input [6:0] ofs;
    input [15:0] pcv;
    input [7:0] sr;
    input [7:0] res;
    input [3:0] sts;
    begin
        case (a)
            `BSSE_ADDR_CMD: read_mux = {23'h000000, cmd};
            `BSSE_ADDR_OPERAND: read_mux = {8'h00, opd};
            `BSSE_ADDR_OFFSET: read_mux = {25'h0000000, ofs};
            `BSSE_ADDR_PC: read_mux = {16'h0000, pcv};
            `BSSE_ADDR_FLAGS: read_mux = {24'h000000, sr};
            `BSSE_ADDR_RESULT: read_mux = {24'h000000, res};
            `BSSE_ADDR_STATUS: read_mux = {28'h0000000, sts};
            default: read_mux = 32'h00000000;
        endcase
    end
endfunction

// ====================================================================
// branch condition decode
reg br_op;
reg br_take;

always @*
begin
    br_op = 1'b1;
    br_take = 1'b0;
    case (op)
        `BSSE_OP_BFS: br_take = status_register_q[bidx]; // RULE_06
        `BSSE_OP_BFC: br_take = ~status_register_q[bidx]; // RULE_07
        `BSSE_OP_BEQ: br_take = status_register_q[`BSSE_FLAG_Z]; // RULE_08
        `BSSE_OP_BNE: br_take = ~status_register_q[`BSSE_FLAG_Z]; // RULE_08
        `BSSE_OP_BCS, `BSSE_OP_BLO:
            br_take = status_register_q[`BSSE_FLAG_C]; // RULE_09
        `BSSE_OP_BCC, `BSSE_OP_BSH:
            br_take = ~status_register_q[`BSSE_FLAG_C]; // RULE_09
        `BSSE_OP_BMI: br_take = status_register_q[`BSSE_FLAG_N]; // RULE_10
        `BSSE_OP_BPL: br_take = ~status_register_q[`BSSE_FLAG_N]; // RULE_10
        `BSSE_OP_BGE:
            br_take = ~(status_register_q[`BSSE_FLAG_N]
                ^ status_register_q[`BSSE_FLAG_V]); // RULE_11
        `BSSE_OP_BLT:
            br_take = status_register_q[`BSSE_FLAG_N]
                ^ status_register_q[`BSSE_FLAG_V]; // RULE_11
        `BSSE_OP_BHS: br_take = status_register_q[`BSSE_FLAG_H]; // RULE_12
        `BSSE_OP_BHC: br_take = ~status_register_q[`BSSE_FLAG_H]; // RULE_12
        `BSSE_OP_BTS: br_take = status_register_q[`BSSE_FLAG_T]; // RULE_13
        `BSSE_OP_BTC: br_take = ~status_register_q[`BSSE_FLAG_T]; // RULE_13
        `BSSE_OP_BVS: br_take = status_register_q[`BSSE_FLAG_V]; // RULE_14
        `BSSE_OP_BVC: br_take = ~status_register_q[`BSSE_FLAG_V]; // RULE_14
        `BSSE_OP_BIE: br_take = status_register_q[`BSSE_FLAG_I]; // RULE_15
        `BSSE_OP_BID: br_take = ~status_register_q[`BSSE_FLAG_I]; // RULE_15
        default: br_op = 1'b0;
    endcase
end

// ====================================================================
// compare and shift datapath
reg [8:0] diff;
reg [7:0] res;
reg [7:0] flags_nx;
reg c_in;
reg upd;
reg skip_op;
reg skip_take;
reg fl_n;
reg fl_v;
reg fl_c;

always @*
begin
    flags_nx = status_register_q;
    res = result_q;
    upd = 1'b0;
    skip_op = (op >= `BSSE_OP_SKRC) && (op <= `BSSE_OP_SKIS);
    skip_take = 1'b0;
    fl_n = 1'b0;
    fl_v = 1'b0;
    fl_c = 1'b0;
    c_in = (op == `BSSE_OP_CMPC) ? status_register_q[`BSSE_FLAG_C] : 1'b0;
    diff = {1'b0, rd_v} - {1'b0, rr_v} - {8'h00, c_in};
    case (op)
        `BSSE_OP_CMPC, `BSSE_OP_CMPI:
        begin
            // difference is discarded, only the flags move
            fl_n = diff[7];
            fl_v = (rd_v[7] & ~rr_v[7] & ~diff[7])
                | (~rd_v[7] & rr_v[7] & diff[7]);
            flags_nx[`BSSE_FLAG_C] = (~rd_v[7] & rr_v[7])
                | (rr_v[7] & diff[7]) | (diff[7] & ~rd_v[7]); // RULE_01
            flags_nx[`BSSE_FLAG_H] = (~rd_v[3] & rr_v[3])
                | (rr_v[3] & diff[3]) | (diff[3] & ~rd_v[3]); // RULE_01
            flags_nx[`BSSE_FLAG_N] = fl_n;
            flags_nx[`BSSE_FLAG_V] = fl_v;
            flags_nx[`BSSE_FLAG_S] = fl_n ^ fl_v;
            // with carry, zero only survives if it was already set
            if (op == `BSSE_OP_CMPC)
                flags_nx[`BSSE_FLAG_Z] = (diff[7:0] == 8'h00)
                    & status_register_q[`BSSE_FLAG_Z]; // RULE_01
            else
                flags_nx[`BSSE_FLAG_Z] = (diff[7:0] == 8'h00); // RULE_01
        end
        `BSSE_OP_SKRC: skip_take = ~rd_v[bidx]; // RULE_02
        `BSSE_OP_SKRS: skip_take = rd_v[bidx]; // RULE_03
        `BSSE_OP_SKIC: skip_take = ~io_v[bidx]; // RULE_04
        `BSSE_OP_SKIS: skip_take = io_v[bidx]; // RULE_05
        `BSSE_OP_SHLL:
        begin
            upd = 1'b1;
            res = {rd_v[6:0], 1'b0}; // RULE_16
            fl_c = rd_v[7];
            flags_nx[`BSSE_FLAG_H] = rd_v[3]; // RULE_16
        end
        `BSSE_OP_ROTL:
        begin
            upd = 1'b1;
            res = {rd_v[6:0], status_register_q[`BSSE_FLAG_C]}; // RULE_18
            fl_c = rd_v[7]; // RULE_18
            flags_nx[`BSSE_FLAG_H] = rd_v[3]; // RULE_18
        end
        `BSSE_OP_SHRL:
        begin
            upd = 1'b1;
            res = {1'b0, rd_v[7:1]}; // RULE_17
            fl_c = rd_v[0];
        end
        `BSSE_OP_ROTR:
        begin
            upd = 1'b1;
            res = {status_register_q[`BSSE_FLAG_C], rd_v[7:1]}; // RULE_19
            fl_c = rd_v[0]; // RULE_19
        end
        `BSSE_OP_SHRA:
        begin
            upd = 1'b1;
            res = {rd_v[7], rd_v[7:1]}; // RULE_20
            fl_c = rd_v[0]; // RULE_20
        end
        default: upd = 1'b0;
    endcase
    if (upd)
    begin
        // overflow is negative xor carry after any shift or rotate
        flags_nx[`BSSE_FLAG_C] = fl_c;
        flags_nx[`BSSE_FLAG_N] = res[7];
        flags_nx[`BSSE_FLAG_V] = res[7] ^ fl_c;
        flags_nx[`BSSE_FLAG_Z] = (res == 8'h00);
    end
end

// ====================================================================
// next program counter and cycle count
reg [15:0] pc_nx;
reg [1:0] cyc_nx;
reg take_nx;

always @*
begin
    pc_nx = pc_q + 16'h0001; // RULE_22
    cyc_nx = `BSSE_CYC_ONE;
    take_nx = 1'b0;
    if (skip_op && skip_take)
    begin
        take_nx = 1'b1;
        if (cmd_q[`BSSE_CMD_TWO_WORD])
        begin
            pc_nx = pc_q + 16'h0003; // RULE_21
            cyc_nx = `BSSE_CYC_THREE; // RULE_21
        end
        else
        begin
            pc_nx = pc_q + 16'h0002; // RULE_21
            cyc_nx = `BSSE_CYC_TWO; // RULE_21
        end
    end
    else if (br_op && br_take)
    begin
        take_nx = 1'b1;
        pc_nx = pc_q + ofs_ext + 16'h0001; // RULE_22
        cyc_nx = `BSSE_CYC_TWO; // RULE_06
    end
end

// ====================================================================
// sequencer
always @*
begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
        ST_IDLE:
        begin
            if (apb_fire && pwrite && !pslverr && paddr == `BSSE_ADDR_CMD)
                state_d = ST_EXEC;
        end
        ST_EXEC:
        begin
            cnt_d = cyc_nx - `BSSE_CYC_ONE;
            if (cyc_nx == `BSSE_CYC_ONE)
                state_d = ST_IDLE; // RULE_22
            else
                state_d = ST_WAIT;
        end
        ST_WAIT:
        begin
            cnt_d = cnt_q - `BSSE_CYC_ONE;
            if (cnt_q == `BSSE_CYC_ONE)
                state_d = ST_IDLE;
        end
        default:
        begin
            state_d = ST_IDLE;
            cnt_d = 2'h0;
        end
    endcase
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state_q <= ST_IDLE;
        cnt_q <= 2'h0;
        cyc_q <= 2'h0;
        taken_q <= 1'b0;
        result_q <= 8'h00;
    end
    else
    begin
        state_q <= state_d;
        cnt_q <= cnt_d;
        if (state_q == ST_EXEC)
        begin
            cyc_q <= cyc_nx;
            taken_q <= take_nx;
            result_q <= res;
        end
    end
end

// ====================================================================
// register file and apb slave
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        cmd_q <= `BSSE_RST_CMD;
        operand_q <= `BSSE_RST_OPERAND;
        offset_q <= `BSSE_RST_OFFSET;
        pc_q <= `BSSE_RST_PC;
        status_register_q <= `BSSE_RST_FLAGS;
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
        pc_out <= `BSSE_RST_PC;
        status_register_out <= `BSSE_RST_FLAGS;
        busy <= 1'b0;
    end
    else
    begin
        // zero wait states: ready is raised for every access phase
        pready <= setup_ph;
        pslverr <= setup_ph & (~mapped(paddr)
            | (pwrite & (paddr == `BSSE_ADDR_CMD) & (state_q != ST_IDLE))
            | (pwrite & (paddr == `BSSE_ADDR_RESULT))
            | (pwrite & (paddr == `BSSE_ADDR_STATUS)));
        if (setup_ph)
            prdata <= read_mux(paddr, cmd_q, operand_q, offset_q, pc_q,
                status_register_q, result_q,
                {taken_q, cyc_q, state_q != ST_IDLE});
        if (apb_fire && pwrite && !pslverr)
        begin
            case (paddr)
                `BSSE_ADDR_CMD: cmd_q <= pwdata[8:0];
                `BSSE_ADDR_OPERAND: operand_q <= pwdata[23:0];
                `BSSE_ADDR_OFFSET: offset_q <= pwdata[6:0];
                `BSSE_ADDR_PC: pc_q <= pwdata[15:0];
                `BSSE_ADDR_FLAGS: status_register_q <= pwdata[7:0];
                default: cmd_q <= cmd_q;
            endcase
        end
        if (state_q == ST_EXEC)
        begin
            pc_q <= pc_nx;
            status_register_q <= flags_nx; // RULE_02
        end
        pc_out <= (state_q == ST_EXEC) ? pc_nx : pc_q;
        status_register_out <= (state_q == ST_EXEC) ? flags_nx
            : status_register_q;
        busy <= (state_d != ST_IDLE);
    end
end

endmodule

// *** test/bsse_mem_model.sv ***
`timescale 1ns/10ps
module bsse_mem_model
(
    // lookup
    input wire [3:0] reg_idx,
    input wire [5:0] io_idx,
    // contents
    output wire [7:0] reg_val,
    output wire [7:0] io_val
);
    reg [7:0] regs [0:15];
    reg [7:0] ios [0:63];
    integer i;

    // fixed contents: zero, sign and half-carry patterns all occur
    initial
    begin
        for (i = 0; i < 64; i = i + 1)
        begin
            ios[i] = (i * 8'h4B) ^ 8'hA5;
            if (i < 16)
                regs[i] = i * 8'h1D;
        end
    end

    assign reg_val = regs[reg_idx];
    assign io_val = ios[io_idx];
endmodule

// *** test/bsse_exec_chk.sv ***
`timescale 1ns/10ps
module bsse_exec_chk
(
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // core state
    input wire [15:0] pc_out,
    input wire [7:0] status_register_out,
    input wire busy
);
    reg [4:0] op_q;
    reg [15:0] ofs_q;
    wire wr_ok = psel && penable && pready && pwrite && !pslverr;
    wire is_one = op_q < 5'h02 || op_q > 5'h19;
    wire is_skip = op_q > 5'h01 && op_q < 5'h06;
    wire is_br = op_q > 5'h05 && op_q < 5'h1A;

    // =====
    // last accepted command and offset
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            op_q <= 5'h1F;
            ofs_q <= 16'h0000;
        end
        else
        begin
            if (wr_ok && paddr == 12'h000)
                op_q <= pwdata[4:0];
            if (wr_ok && paddr == 12'h008)
                ofs_q <= {{9{pwdata[6]}}, pwdata[6:0]};
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // =====
    // assertions
    setup_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    unmapped_err_a: assert property (pready && paddr > 12'h018
        |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
    ro_write_a: assert property (pready && pwrite
        && (paddr == 12'h014 || paddr == 12'h018) |-> pslverr)
        else $error("read-only write accepted");
    cmd_start_a: assert property (wr_ok && paddr == 12'h000 |=> busy)
        else $error("command did not start");
    cmd_refuse_a: assert property (pready && pwrite && paddr == 12'h000
        && busy && $past(busy) |-> pslverr) else $error("busy cmd taken");
    busy_len_a: assert property ($rose(busy) |-> ##[1:3] !busy)
        else $error("busy too long");
    one_cycle_a: assert property ($rose(busy) && is_one
        |=> !busy && pc_out == $past(pc_out) + 16'h0001)
        else $error("one cycle op wrong");
    flags_hold_a: assert property ($rose(busy) && !is_one
        |=> $stable(status_register_out)) else $error("flags changed");
    branch_pc_a: assert property ($rose(busy) && is_br |=>
        (busy && pc_out == $past(pc_out) + ofs_q + 16'h0001 ##1 !busy)
        or (!busy && pc_out == $past(pc_out) + 16'h0001))
        else $error("branch pc wrong");
    skip_pc_a: assert property ($rose(busy) && is_skip |=>
        (!busy && pc_out == $past(pc_out) + 16'h0001)
        or (busy && pc_out == $past(pc_out) + 16'h0002 ##1 !busy)
        or (busy && pc_out == $past(pc_out) + 16'h0003 ##1 busy ##1 !busy))
        else $error("skip pc wrong");

    taken_c: cover property ($rose(busy) && is_br ##1 busy);
    skip3_c: cover property ($rose(busy) && is_skip ##2 busy);
    refuse_c: cover property (pready && pslverr);
endmodule

bind bsse_exec bsse_exec_chk chk
(
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .pc_out(pc_out),
    .status_register_out(status_register_out),
    .busy(busy)
);

// *** test/tb_branch_skip_shift_exec.sv ***
`timescale 1ns/10ps
module tb_branch_skip_shift_exec;
    reg pclk;
    reg presetn;
    reg psel;
    reg penable;
    reg pwrite;
    reg [11:0] paddr;
    reg [31:0] pwdata;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire [15:0] pc_out;
    wire [7:0] sr_out;
    wire busy;
    wire [7:0] rval;
    wire [7:0] ival;
    integer failures;
    integer n_checks;
    integer seed;
    integer i;
    integer j;
    reg [3:0] ridx;
    reg [5:0] iidx;
    reg [31:0] rnd;
    reg [31:0] rnd2;
    reg [31:0] rd;
    reg err;
    reg [4:0] cur_op;
    reg [15:0] e_pc;
    reg [7:0] e_sr;
    reg [7:0] e_res;
    reg [1:0] e_cyc;
    reg e_tk;

    bsse_exec dut
    (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .pc_out(pc_out),
        .status_register_out(sr_out),
        .busy(busy)
    );

    bsse_mem_model mem
    (
        .reg_idx(ridx),
        .io_idx(iidx),
        .reg_val(rval),
        .io_val(ival)
    );

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // =====
    // bench tasks
    task chk(input [31:0] got, input [31:0] exp);
    begin
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    end
    endtask

    task apb(input w, input [11:0] a, input [31:0] d);
        integer n;
    begin
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n = n + 1;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            failures = failures + 1;
            summarize;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask

    task model(input [8:0] cmd, input [23:0] opd, input [6:0] k,
               input [15:0] pc, input [7:0] sr);
        reg [4:0] op;
        reg [3:0] p;
        reg [7:0] d;
        reg [7:0] r;
        reg [7:0] x;
        reg [7:0] q;
        reg f;
        reg cond;
        reg cn;
        reg v;
    begin
        op = cmd[4:0];
        p = op[4:1] - 4'h4;
        d = opd[7:0];
        r = opd[15:8];
        x = opd[23:16];
        e_sr = sr;
        e_pc = pc + 16'h0001;
        e_cyc = 2'h1;
        e_tk = 1'b0;
        e_res = 8'h00;
        case (p)
            4'h0: f = sr[1];
            4'h1, 4'h2: f = sr[0];
            4'h3: f = sr[2];
            4'h4: f = sr[2] ^ sr[3];
            4'h5: f = sr[5];
            4'h6: f = sr[6];
            4'h7: f = sr[3];
            default: f = sr[7];
        endcase
        case (op)
            5'h02: cond = !d[cmd[7:5]];
            5'h03: cond = d[cmd[7:5]];
            5'h04: cond = !x[cmd[7:5]];
            5'h05: cond = x[cmd[7:5]];
            5'h06: cond = sr[cmd[7:5]];
            5'h07: cond = !sr[cmd[7:5]];
            default: cond = op > 5'h07 && op < 5'h1A
                && (f ^ op[0] ^ (p == 4'h2 || p == 4'h4));
        endcase
        e_tk = cond;
        if (cond && op < 5'h06)
        begin
            e_cyc = {1'b1, cmd[8]};
            e_pc = pc + {14'h0, e_cyc};
        end
        else if (cond)
        begin
            e_cyc = 2'h2;
            e_pc = pc + {{9{k[6]}}, k} + 16'h0001;
        end
        if (op < 5'h02)
        begin
            q = d - r - (op == 5'h00 ? sr[0] : 1'b0);
            v = (d[7] & !r[7] & !q[7]) | (!d[7] & r[7] & q[7]);
            e_sr = {sr[7:6], (!d[3] & r[3]) | (r[3] & q[3]) | (q[3] & !d[3]),
                q[7] ^ v, v, q[7], q == 8'h00 && (op[0] || sr[1]),
                (!d[7] & r[7]) | (r[7] & q[7]) | (q[7] & !d[7])};
        end
        if (op > 5'h19 && op < 5'h1F)
        begin
            case (op)
                5'h1A: {cn, q} = {d, 1'b0};
                5'h1B: {q, cn} = {1'b0, d};
                5'h1C: {cn, q} = {d, sr[0]};
                5'h1D: {q, cn} = {sr[0], d};
                default: {q, cn} = {d[7], d};
            endcase
            e_sr = {sr[7:6], (op == 5'h1A || op == 5'h1C) ? d[3] : sr[5],
                sr[4], q[7] ^ cn, q[7], q == 8'h00, cn};
            e_res = q;
        end
    end
    endtask

    task run(input [8:0] cmd, input [23:0] opd, input [6:0] k,
             input [15:0] pc, input [7:0] sr);
    begin
        cur_op = cmd[4:0];
        apb(1'b1, 12'h004, {8'h0, opd});
        apb(1'b1, 12'h008, {25'h0, k});
        apb(1'b1, 12'h00C, {16'h0, pc});
        apb(1'b1, 12'h010, {24'h0, sr});
        apb(1'b1, 12'h000, {23'h0, cmd});
        chk({31'h0, err}, 32'h0);
        model(cmd, opd, k, pc, sr);
    end
    endtask

    task fin;
        integer n;
    begin
        n = 0;
        do
        begin
            @(posedge pclk);
            n = n + 1;
        end
        while (busy !== 1'b0 && n < 8);
        chk({31'h0, busy}, 32'h0);
        chk({16'h0, pc_out}, {16'h0, e_pc});
        chk({24'h0, sr_out}, {24'h0, e_sr});
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd, {16'h0, e_pc});
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, {24'h0, e_sr});
        apb(1'b0, 12'h018, 32'h0);
        chk(rd, {28'h0, e_tk, e_cyc, 1'b0});
        if (cur_op > 5'h19 && cur_op < 5'h1F)
        begin
            apb(1'b0, 12'h014, 32'h0);
            chk(rd, {24'h0, e_res});
        end
    end
    endtask

    task summarize;
    begin
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask

    // =====
    // main sequence
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = 46'h0;
        presetn = 1'b0;
        failures = 0;
        n_checks = 0;
        seed = 52223;
        ridx = 4'h0;
        iidx = 6'h00;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd, 32'h0);
        for (i = 0; i < 32; i = i + 1)
            for (j = 0; j < 6; j = j + 1)
            begin
                rnd = $random(seed);
                rnd2 = $random(seed);
                ridx <= rnd[27:24];
                iidx <= rnd[31:26];
                @(posedge pclk);
                run({rnd[8:5], i[4:0]},
                    {ival, (i == 2 || i == 3) ? rval : rnd[23:16], rval},
                    j == 0 ? 7'h40 : j == 1 ? 7'h3F : rnd[15:9],
                    rnd2[15:0], rnd2[23:16]);
                fin;
            end
        $display("all operation codes done");
        apb(1'b0, 12'h01C, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        apb(1'b1, 12'h014, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, 12'h018, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("refused accesses done");
        run(9'h102, 24'h0, 7'h05, 16'h0100, 8'hC3);
        apb(1'b1, 12'h000, 32'h1F);
        chk({31'h0, err}, 32'h1);
        fin;
        $display("busy refusal done");
        run(9'h018, 24'h0, 7'h10, 16'h0200, 8'h80);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd, 32'h0);
        $display("reset in mid-run done");
        summarize;
    end

    initial
    begin
        #200000;
        failures = failures + 1;
        summarize;
    end
endmodule
